// *** rtl/plscr_pkg.sv ***
// Purpose: Shared constants and carriers for the link status and capability register block.
// Assumes: Avalon-MM slave with 32-bit data and byte addresses.
// Notes: Offsets are byte addresses of aligned words.
package plscr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] DEV_ERR_STATUS_OFS = 8'hB8;
  localparam logic [7:0] LINK_CAP_OFS = 8'hBC;
  localparam logic [7:0] LINK_CTRL_OFS = 8'hC0;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'hE0;
  localparam logic [7:0] IRQ_MASK_OFS = 8'hE4;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ERR_FLAG_LSB = 16;
  localparam int AUX_PWR_BIT = 20;
  localparam int TXN_PEND_BIT = 21;
  localparam int CAP_SPEED_LSB = 0;
  localparam int CAP_WIDTH_LSB = 4;
  localparam int CAP_ASPM_LSB = 10;
  localparam int CAP_L0S_LSB = 12;
  localparam int CAP_L1_LSB = 15;
  localparam int CAP_CLKPM_BIT = 18;
  localparam int CTRL_ASPM_LSB = 0;
  localparam int CTRL_CCC_BIT = 6;
  localparam int CTRL_ESYNC_BIT = 7;
  localparam int CTRL_CLKPM_BIT = 8;

  // ----------------------------------------
  // Fixed values and reset values
  // ----------------------------------------
  localparam logic [3:0] LINK_SPEED_2G5 = 4'h1;
  localparam logic [5:0] LINK_WIDTH_X1 = 6'h01;
  localparam logic [1:0] ASPM_SUPPORT_L0S_L1 = 2'h3;
  localparam logic [2:0] L0S_EXIT_LAT = 3'h3;
  localparam logic [2:0] L1_EXIT_LAT_OFF = 3'h0;
  localparam logic [2:0] L1_EXIT_LAT_ON = 3'h6;
  localparam logic [7:0] PORT_NUMBER = 8'h00;
  localparam logic [1:0] STRAP_ENABLE_VAL = 2'h0;
  localparam logic [1:0] STRAP_TAKE_CNT = 2'h2;
  localparam logic [3:0] ERR_FLAGS_RST = 4'h0;
  localparam logic [3:0] ERR_EN_RST = 4'h0;
  localparam logic [1:0] ASPM_CTRL_RST = 2'h0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic unsup_req;
    logic fatal;
    logic non_fatal;
    logic correctable;
  } plscr_err_s;

  typedef struct packed {
    logic ext_sync;
    logic common_clk;
    logic [1:0] aspm;
  } plscr_ctrl_s;

endpackage

// *** rtl/plscr_regs.sv ***
// Purpose: Device error status, link capability and link control registers of an express upstream port.
// Assumes: Single 50 MHz core clock; request strap pins arrive asynchronously from the board.
// Notes: Avalon-MM slave answers every access in one wait cycle; error flags also raise an interrupt.
`timescale 1ns/100ps

// What this block does
// R1 - Four error-detected flags sit at status bits 16 to 19, reset to zero and clear when a one is written to them.
// R2 - Status bit 20 reads one as the auxiliary power indication and cannot be written.
// R3 - Status bit 21 shows whether a transaction is outstanding, resets to zero, and bits 31 to 22 read zero.
// R4 - Capability bits 3 to 0 read the fixed 2.5 Gb/s speed code 0001.
// R5 - Capability bits 9 to 4 report the single-lane width code 000001.
// R6 - Capability bits 11 to 10 report support for both L0s and L1 as 11.
// R7 - Capability bits 14 to 12 report the L0s exit latency code 3h.
// R8 - Capability bits 17 to 15 report L1 exit latency 0h, or 6h when clock power management is strapped on.
// R9 - Clock power management is enabled only when strap pins 3 and 2 are both low as reset is released.
// R10 - Capability bit 18 reads one exactly when clock power management is strapped on.
// R11 - Capability bits 19 to 31 read zero, including the link active reporting bit and port number 00h.
// R12 - Control bits 1 to 0 select the power management states and reset to 00.
// R13 - Control bits 2, 3 and 15 to 9 read zero.
// R14 - Control bit 8 is writable only when clock power management is strapped on and resets to zero.
// R15 - Control bits 4 and 5 read zero while bits 6 and 7 are writable and reset to zero.
// R16 - Writes to read-only bits do nothing and writing zero leaves an error flag unchanged.
// R17 - Error reporting enables sit at bits 3 to 0 of the status word and reset to zero.
module plscr_regs (
  input wire logic i_core_clk, // Core clock, 50 MHz.
  input wire logic i_reset_n, // Asynchronous active-low reset.
  input wire logic [7:0] i_avs_address, // Byte address.
  input wire logic i_avs_read, // Read request.
  input wire logic i_avs_write, // Write request.
  input wire logic [31:0] i_avs_writedata, // Write data.
  input wire logic [3:0] i_avs_byteenable, // Byte lane enables.
  output logic [31:0] o_avs_readdata, // Read data.
  output logic o_avs_waitrequest, // Stall while high.
  input wire logic [3:0] i_req_strap_n, // Request strap pins from the board.
  input wire logic i_txn_pending, // Transaction layer has outstanding work.
  input wire plscr_pkg::plscr_err_s i_err_event, // One-cycle error detection pulses.
  output plscr_pkg::plscr_err_s o_err_report_en, // Error reporting enables.
  output plscr_pkg::plscr_ctrl_s o_link_ctrl, // ASPM, common clock and extended sync controls.
  output logic o_clk_pm_en, // Clock power management enabled by software.
  output logic o_clk_pm_capable, // Clock power management strapped on.
  output logic o_irq // Level interrupt.
);

  logic [1:0] strap_meta_ff;
  logic [1:0] strap_sync_ff;
  logic strap_done_ff;
  logic [1:0] strap_cnt_ff;
  logic clk_pm_cap_ff;
  logic txn_meta_ff;
  logic txn_sync_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  plscr_pkg::plscr_err_s err_flags_ff;
  plscr_pkg::plscr_err_s err_en_ff;
  plscr_pkg::plscr_ctrl_s ctrl_ff;
  logic clk_pm_en_ff;
  logic [3:0] irq_mask_ff;
  logic req;
  logic wr_hit;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] status_word;
  logic [31:0] cap_word;
  logic [31:0] ctrl_word;
  logic [31:0] nxt_rdata;
  logic [3:0] err_clr;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lanes_to_mask(input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return m;
  endfunction

  function automatic logic is_write_to(input logic hit, input logic [7:0] addr, input logic [7:0] ofs);
    logic r;
    r = hit && (addr == ofs);
    return r;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      strap_meta_ff <= 2'h0;
      strap_sync_ff <= 2'h0;
    end
    else
    begin
      strap_meta_ff <= i_req_strap_n[3:2];
      strap_sync_ff <= strap_meta_ff;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      txn_meta_ff <= 1'b0;
      txn_sync_ff <= 1'b0;
    end
    else
    begin
      txn_meta_ff <= i_txn_pending;
      txn_sync_ff <= txn_meta_ff;
    end
  end

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // The strap is taken once from the second stage, when it first holds pins sampled after release.
  // Taking it earlier would read the reset value of the synchroniser, which looks like an enable.
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      strap_done_ff <= 1'b0;
      strap_cnt_ff <= 2'h0;
      clk_pm_cap_ff <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == plscr_pkg::STRAP_TAKE_CNT)
      begin
        strap_done_ff <= 1'b1;
        clk_pm_cap_ff <= (strap_sync_ff == plscr_pkg::STRAP_ENABLE_VAL); // R9
      end
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  assign req = (i_avs_read || i_avs_write) && !ack_ff;
  // A write lands at the edge where the master sees waitrequest low.
  assign wr_hit = i_avs_write && ack_ff;
  assign wmask = lanes_to_mask(i_avs_byteenable);
  assign wbits = i_avs_writedata & wmask;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req;
    end
  end

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  always_comb
  begin
    status_word = 32'h0000_0000; // R3
    status_word[plscr_pkg::ERR_FLAG_LSB +: 4] = err_flags_ff; // R1
    status_word[plscr_pkg::AUX_PWR_BIT] = 1'b1; // R2
    status_word[plscr_pkg::TXN_PEND_BIT] = txn_sync_ff; // R3
    status_word[3:0] = err_en_ff; // R17
  end

  always_comb
  begin
    cap_word = 32'h0000_0000; // R11
    cap_word[plscr_pkg::CAP_SPEED_LSB +: 4] = plscr_pkg::LINK_SPEED_2G5; // R4
    cap_word[plscr_pkg::CAP_WIDTH_LSB +: 6] = plscr_pkg::LINK_WIDTH_X1; // R5
    cap_word[plscr_pkg::CAP_ASPM_LSB +: 2] = plscr_pkg::ASPM_SUPPORT_L0S_L1; // R6
    cap_word[plscr_pkg::CAP_L0S_LSB +: 3] = plscr_pkg::L0S_EXIT_LAT; // R7
    cap_word[plscr_pkg::CAP_L1_LSB +: 3] = clk_pm_cap_ff ? plscr_pkg::L1_EXIT_LAT_ON
                                                         : plscr_pkg::L1_EXIT_LAT_OFF; // R8
    cap_word[plscr_pkg::CAP_CLKPM_BIT] = clk_pm_cap_ff; // R10
    cap_word[31:24] = plscr_pkg::PORT_NUMBER; // R11
  end

  always_comb
  begin
    ctrl_word = 32'h0000_0000; // R13 R15
    ctrl_word[plscr_pkg::CTRL_ASPM_LSB +: 2] = ctrl_ff.aspm; // R12
    ctrl_word[plscr_pkg::CTRL_CCC_BIT] = ctrl_ff.common_clk; // R15
    ctrl_word[plscr_pkg::CTRL_ESYNC_BIT] = ctrl_ff.ext_sync; // R15
    ctrl_word[plscr_pkg::CTRL_CLKPM_BIT] = clk_pm_en_ff; // R14
  end

  always_comb
  begin
    if (i_avs_address == plscr_pkg::DEV_ERR_STATUS_OFS)
    begin
      nxt_rdata = status_word;
    end
    else if (i_avs_address == plscr_pkg::LINK_CAP_OFS)
    begin
      nxt_rdata = cap_word;
    end
    else if (i_avs_address == plscr_pkg::LINK_CTRL_OFS)
    begin
      nxt_rdata = ctrl_word;
    end
    else if (i_avs_address == plscr_pkg::IRQ_STATUS_OFS)
    begin
      nxt_rdata = {28'h000_0000, err_flags_ff};
    end
    else if (i_avs_address == plscr_pkg::IRQ_MASK_OFS)
    begin
      nxt_rdata = {28'h000_0000, irq_mask_ff};
    end
    else
    begin
      nxt_rdata = plscr_pkg::UNMAPPED_READ;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else if (i_avs_read && !ack_ff)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_avs_readdata = rdata_ff;

  // ----------------------------------------
  // Error flags
  // ----------------------------------------
  always_comb
  begin
    err_clr = 4'h0;
    if (is_write_to(wr_hit, i_avs_address, plscr_pkg::DEV_ERR_STATUS_OFS))
    begin
      err_clr = wbits[plscr_pkg::ERR_FLAG_LSB +: 4]; // R1 R16
    end
    else if (is_write_to(wr_hit, i_avs_address, plscr_pkg::IRQ_STATUS_OFS))
    begin
      err_clr = wbits[3:0];
    end
  end

  // A new event in the cycle of a clear keeps its flag set.
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      err_flags_ff <= plscr_pkg::ERR_FLAGS_RST; // R1
    end
    else
    begin
      err_flags_ff <= (err_flags_ff & ~err_clr) | i_err_event; // R1 R16
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      err_en_ff <= plscr_pkg::ERR_EN_RST; // R17
    end
    else if (is_write_to(wr_hit, i_avs_address, plscr_pkg::DEV_ERR_STATUS_OFS) && i_avs_byteenable[0])
    begin
      err_en_ff <= i_avs_writedata[3:0]; // R17
    end
  end

  // ----------------------------------------
  // Link control
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_ff <= '{ext_sync: 1'b0, common_clk: 1'b0, aspm: plscr_pkg::ASPM_CTRL_RST}; // R12 R15
    end
    else if (is_write_to(wr_hit, i_avs_address, plscr_pkg::LINK_CTRL_OFS) && i_avs_byteenable[0])
    begin
      ctrl_ff.aspm <= i_avs_writedata[plscr_pkg::CTRL_ASPM_LSB +: 2]; // R12
      ctrl_ff.common_clk <= i_avs_writedata[plscr_pkg::CTRL_CCC_BIT]; // R15
      ctrl_ff.ext_sync <= i_avs_writedata[plscr_pkg::CTRL_ESYNC_BIT]; // R15
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      clk_pm_en_ff <= 1'b0; // R14
    end
    else if (clk_pm_cap_ff && is_write_to(wr_hit, i_avs_address, plscr_pkg::LINK_CTRL_OFS)
             && i_avs_byteenable[1])
    begin
      clk_pm_en_ff <= i_avs_writedata[plscr_pkg::CTRL_CLKPM_BIT]; // R14
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      irq_mask_ff <= plscr_pkg::IRQ_MASK_RST;
    end
    else if (is_write_to(wr_hit, i_avs_address, plscr_pkg::IRQ_MASK_OFS) && i_avs_byteenable[0])
    begin
      irq_mask_ff <= i_avs_writedata[3:0];
    end
  end

  assign o_irq = |(err_flags_ff & irq_mask_ff);
  assign o_err_report_en = err_en_ff;
  assign o_link_ctrl = ctrl_ff;
  assign o_clk_pm_en = clk_pm_en_ff;
  assign o_clk_pm_capable = clk_pm_cap_ff;

endmodule

// *** test/plscr_regs_properties.sv ***
// Purpose: Port-level checks of the link status and capability register block.
// Assumes: One clock, asynchronous active-low reset, one wait cycle per access.
// Notes: Bound to every instance of the register block.
`timescale 1ns/100ps
module plscr_regs_chk (
  input wire logic i_core_clk, // Clock.
  input wire logic i_reset_n, // Reset.
  input wire logic [7:0] i_avs_address, // Address.
  input wire logic i_avs_write, // Write.
  input wire logic [31:0] i_avs_writedata, // Write data.
  input wire logic [3:0] i_avs_byteenable, // Lanes.
  input wire logic o_avs_waitrequest, // Stall.
  input wire plscr_pkg::plscr_err_s i_err_event, // Events.
  input wire plscr_pkg::plscr_err_s o_err_report_en, // Enables.
  input wire plscr_pkg::plscr_ctrl_s o_link_ctrl, // Controls.
  input wire logic o_clk_pm_en, // Clock pm enable.
  input wire logic o_clk_pm_capable, // Strap result.
  input wire logic o_irq // Interrupt.
);
  logic [2:0] rel_cnt_ff;
  logic wr_ok;
  logic wr_st;
  logic wr_ct;
  assign wr_ok = i_avs_write && !o_avs_waitrequest;
  assign wr_st = wr_ok && i_avs_address == plscr_pkg::DEV_ERR_STATUS_OFS;
  assign wr_ct = wr_ok && i_avs_address == plscr_pkg::LINK_CTRL_OFS;
  // Counts edges since reset release so the strap result is judged only once settled.
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rel_cnt_ff <= 3'h0;
    else if (rel_cnt_ff != 3'h7)
      rel_cnt_ff <= rel_cnt_ff + 3'h1;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  AST_ERR_EN_WR: assert property (
    wr_st && i_avs_byteenable[0] |=> o_err_report_en == $past(i_avs_writedata[3:0])) else $error("enable write lost");
  AST_ERR_EN_HOLD: assert property (
    !wr_st |=> $stable(o_err_report_en)) else $error("enables changed without write");
  AST_CTRL_WR: assert property (
    wr_ct && i_avs_byteenable[0] |=> o_link_ctrl == {$past(i_avs_writedata[7:6]), $past(i_avs_writedata[1:0])})
    else $error("control write lost");
  AST_CTRL_HOLD: assert property (
    !wr_ct |=> $stable(o_link_ctrl)) else $error("control changed without write");
  AST_PM_EN_RO: assert property (
    !o_clk_pm_capable |-> !o_clk_pm_en) else $error("clock pm enabled while not strapped");
  AST_PM_EN_WR: assert property (
    wr_ct && i_avs_byteenable[1] && o_clk_pm_capable |=> o_clk_pm_en == $past(i_avs_writedata[8]))
    else $error("clock pm enable write lost");
  AST_CAP_STABLE: assert property (
    rel_cnt_ff == 3'h7 |-> $stable(o_clk_pm_capable)) else $error("strap result moved");
  AST_IRQ_RISE: assert property (
    $rose(o_irq) |-> $past(|i_err_event) || $past(wr_ok)) else $error("interrupt rose without cause");
  AST_IRQ_FALL: assert property (
    $fell(o_irq) |-> $past(wr_ok)) else $error("interrupt fell without write");
endmodule
bind plscr_regs plscr_regs_chk i_plscr_regs_chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_avs_address(i_avs_address), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest), .i_err_event(i_err_event),
  .o_err_report_en(o_err_report_en), .o_link_ctrl(o_link_ctrl), .o_clk_pm_en(o_clk_pm_en),
  .o_clk_pm_capable(o_clk_pm_capable), .o_irq(o_irq));

// *** test/plscr_host.sv ***
// Purpose: Configuration host model that masters the register bus.
// Assumes: Caller enters xfer just after a rising edge.
// Notes: Each access ends with one idle cycle.
`timescale 1ns/100ps
module plscr_host (
  input wire logic i_core_clk, // Clock.
  input wire logic i_waitrequest, // Stall.
  input wire logic [31:0] i_readdata, // Read data.
  output logic o_read, // Read.
  output logic o_write, // Write.
  output logic [7:0] o_address, // Address.
  output logic [31:0] o_writedata, // Write data.
  output logic [3:0] o_byteenable // Lanes.
);
  initial
  begin
    o_read = 1'b0;
    o_write = 1'b0;
    o_address = 8'h00;
    o_writedata = 32'h0000_0000;
    o_byteenable = 4'hF;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b,
                      output logic [31:0] q);
    o_read <= !wr;
    o_write <= wr;
    o_address <= a;
    o_writedata <= d;
    o_byteenable <= b;
    @(posedge i_core_clk);
    while (i_waitrequest !== 1'b0)
    begin
      @(posedge i_core_clk);
    end
    q = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
    @(posedge i_core_clk);
  endtask
endmodule

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the register block.
// Assumes: Host model masters the bus; bench drives straps, events and pending.
// Notes: Runs once with clock pm strapped on and once with it off.
`timescale 1ns/100ps
module tb_top;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] strap = 4'h3;
  logic txn = 1'b0;
  plscr_pkg::plscr_err_s ev = 4'h0;
  logic rd, wr, wait_r, pm_en, pm_cap, irq;
  logic [7:0] addr;
  logic [31:0] wd, rdata, q;
  logic [3:0] be;
  plscr_pkg::plscr_err_s en_o;
  plscr_pkg::plscr_ctrl_s ctrl_o;
  int n_mismatch = 0, cmp_count = 0, flags, en, ctrl, mask, cap, pend, e;
  logic [7:0] addrs[6] = '{8'hB8, 8'hBC, 8'hC0, 8'hE0, 8'hE4, 8'h10};
  always #10 i_core_clk = ~i_core_clk;
  plscr_host i_plscr_host (.i_core_clk(i_core_clk), .i_waitrequest(wait_r), .i_readdata(rdata), .o_read(rd),
    .o_write(wr), .o_address(addr), .o_writedata(wd), .o_byteenable(be));
  plscr_regs i_plscr_regs (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .i_req_strap_n(strap), .i_txn_pending(txn), .i_err_event(ev),
    .o_err_report_en(en_o), .o_link_ctrl(ctrl_o), .o_clk_pm_en(pm_en), .o_clk_pm_capable(pm_cap), .o_irq(irq));
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'hB8: return 32'(flags << 16 | 1 << 20 | pend << 21 | en);
      8'hBC: return 32'(1 | 1 << 4 | 3 << 10 | 3 << 12 | (cap ? 6 : 0) << 15 | cap << 18);
      8'hC0: return 32'(ctrl);
      8'hE0: return 32'(flags);
      8'hE4: return 32'(mask);
      default: return 32'h0000_0000;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdc(input logic [7:0] a);
    i_plscr_host.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk($sformatf("reg %h", a), q, exp_rd(a));
    chk("report enables", {28'h000_0000, en_o}, 32'(en));
    chk("link controls", {28'h000_0000, ctrl_o}, 32'({ctrl[7:6], ctrl[1:0]}));
    chk("clock pm enable", {31'h0, pm_en}, 32'(ctrl[8]));
    chk("clock pm capable", {31'h0, pm_cap}, 32'(cap));
  endtask
  task automatic wrm(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    i_plscr_host.xfer(1'b1, a, d, b, q);
    if (a == 8'hB8 && b[0]) en = d[3:0];
    if (a == 8'hB8 && b[2]) flags &= ~32'(d[19:16]);
    if (a == 8'hC0 && b[0]) ctrl = ctrl & ~32'h0000_00C3 | d & 32'h0000_00C3;
    if (a == 8'hC0 && b[1] && cap) ctrl = ctrl & ~32'h0000_0100 | d & 32'h0000_0100;
    if (a == 8'hE0 && b[0]) flags &= ~32'(d[3:0]);
    if (a == 8'hE4 && b[0]) mask = d[3:0];
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(59100));
    for (int s = 0; s < 2; s++)
    begin
      i_reset_n <= 1'b0;
      strap <= s ? 4'hC : 4'h3;
      repeat (16) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      repeat (6) @(posedge i_core_clk);
      flags = 0; en = 0; ctrl = 0; mask = 0; pend = 0; cap = (s == 0);
      foreach (addrs[i]) rdc(addrs[i]);
      $display("reset values done");
      for (int i = 0; i < 8; i++)
      begin
        wrm(8'hC0, {$urandom} & ~32'h3 | 32'(i % 4), i < 4 ? 4'hF : 4'($urandom));
        rdc(8'hC0);
        wrm(8'hBC, $urandom, 4'hF);
        rdc(8'hBC);
      end
      wrm(8'hB8, $urandom, 4'hF);
      rdc(8'hB8);
      $display("control and capability done");
      for (int i = 0; i < 4; i++)
      begin
        e = 1 << i | ($urandom & 15);
        ev <= 4'(e);
        @(posedge i_core_clk);
        ev <= 4'h0;
        @(posedge i_core_clk);
        flags |= e;
        rdc(8'hE0);
        wrm(8'hE4, 0, 4'hF);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wrm(8'hE4, 32'(e), 4'hF);
        chk("irq", {31'h0, irq}, 32'h1);
        wrm(8'hB8, 32'h0000_0000, 4'hF);
        rdc(8'hB8);
        wrm(i[0] ? 8'hE0 : 8'hB8, i[0] ? 32'(e) : 32'(e) << 16, 4'hF);
        chk("irq clear", {31'h0, irq}, 32'(|(flags & mask)));
      end
      $display("error flags done");
      txn <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      pend = 1;
      rdc(8'hB8);
      txn <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      pend = 0;
      rdc(8'hB8);
      $display("pending done");
    end
    end_of_test;
  end
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    n_mismatch++;
    end_of_test;
  end
endmodule
